// ==== hdl/tpoh_pkg.sv ====
//------------------------------------------------------------
// Path overhead insert constants
//------------------------------------------------------------
package tpoh_pkg;
	// Register indices, byte address is four times the index
	localparam logic [11:0] IDX_CTRL0 = 12'h983;
	localparam logic [11:0] IDX_J1_VALUE = 12'h993;
	localparam logic [11:0] IDX_TRACE_CTRL = 12'h9BB;
	localparam logic [11:0] IDX_LABEL_VALUE = 12'h9C0;
	localparam logic [11:0] IDX_STATUS = 12'h9F0;
	localparam int ADDR_W = 16;
	localparam int DATA_W = 32;

	// Control byte 0 fields
	localparam int C0_USER_CH = 7;
	localparam int C0_REI_LO = 5;
	localparam int C0_RDI_LO = 3;
	localparam int C0_LABEL_SRC = 2;
	localparam int C0_AIS = 0;
	localparam logic [7:0] C0_WR_MASK = 8'hFD;
	localparam logic [7:0] CTRL0_RST = 8'h00;

	// Trace control fields
	localparam int TC_LEN_LO = 2;
	localparam int TC_SRC_LO = 0;
	localparam logic [3:0] TRACE_CTRL_RST = 4'h0;
	localparam logic [7:0] LABEL_RST = 8'h00;
	localparam logic [7:0] J1_VALUE_RST = 8'h00;

	// Trace source encodings
	localparam logic [1:0] TSRC_ZERO = 2'h0;
	localparam logic [1:0] TSRC_BUFFER = 2'h1;
	localparam logic [1:0] TSRC_REG = 2'h2;
	localparam logic [1:0] TSRC_SERIAL = 2'h3;

	// Serial link timing
	localparam int PCLK_PERIOD_NS = 50;
	localparam int SER_PERIOD_NS = 400;
	localparam int SER_DIV = SER_PERIOD_NS / PCLK_PERIOD_NS;
	localparam int SER_HALF = SER_DIV / 2;
	localparam int POH_BYTES = 9;
	localparam int WIN_PERIODS = POH_BYTES * 8;
	localparam int FRAME_PERIODS = 312;
	// Capture slots: J1 bits in periods 1..8, C2 after a 16 period wait
	localparam int J1_LAST_PER = 8;
	localparam int C2_WAIT = 16;
	localparam int C2_LAST_PER = C2_WAIT + 8;

	// FIFO word: tag above the byte
	localparam int FIFO_W = 9;
	localparam int FIFO_DEPTH = 4;
	localparam logic TAG_J1 = 1'b0;
	localparam logic TAG_C2 = 1'b1;
endpackage : tpoh_pkg

// ==== hdl/tpoh_fifo.sv ====
`timescale 1ns/1ns
//------------------------------------------------------------
// Small FIFO with registered read data
//------------------------------------------------------------
module tpoh_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 4
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// Drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] DEPTH_C = (AW+1)'(DEPTH);

	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW-1:0] wr_ptr_reg;
	logic [AW-1:0] rd_ptr_reg;
	logic [AW-1:0] rd_ptr_next;
	logic [AW:0] count_reg;
	logic push;
	logic pop;

	// Handshakes; full refuses, empty never pops
	assign in_ready = (count_reg != DEPTH_C);
	assign out_valid = (count_reg != '0);
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	assign rd_ptr_next = pop ? rd_ptr_reg + 1'b1 : rd_ptr_reg;

	// Storage
	always_ff @(posedge pclk) begin
		if (push) begin
			mem_reg[wr_ptr_reg] <= in_data;
		end
	end

	// Pointers and fill level
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg <= '0;
		end else begin
			if (push) begin
				wr_ptr_reg <= wr_ptr_reg + 1'b1;
			end
			rd_ptr_reg <= rd_ptr_next;
			if (push && !pop) begin
				count_reg <= count_reg + 1'b1;
			end else if (pop && !push) begin
				count_reg <= count_reg - 1'b1;
			end
		end
	end

	// Head word register; bypass when the head slot is written now
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			out_data <= '0;
		end else if (push && wr_ptr_reg == rd_ptr_next) begin
			out_data <= in_data;
		end else begin
			out_data <= mem_reg[rd_ptr_next];
		end
	end
endmodule : tpoh_fifo

// ==== hdl/tpoh_insert.sv ====
// Local design decisions: the register offsets and the APB interface to the registers.
`timescale 1ns/1ns
//------------------------------------------------------------
// Transmit path overhead J1 / C2 source selection and serial port
//------------------------------------------------------------
// Behaviour
// - Trace source 11 selects serial J1
// - Serial J1 byte fills every outbound J1
// - Capture each bit at following rising edge
// - Label source 0 sends label register
// - Label register eight bits, read/write, zero reset
// - Label source 1 sends serial C2
// - Control byte 0 field layout, zero reset
// - Trace control: 7:4 zero, length, source
// - Source 00 zero, 01 buffer, 10 register
module tpoh_insert #(
	parameter int FRAME_PERIODS = tpoh_pkg::FRAME_PERIODS,
	parameter int FIFO_DEPTH = tpoh_pkg::FIFO_DEPTH
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [tpoh_pkg::ADDR_W-1:0] paddr,
	input wire logic [tpoh_pkg::DATA_W-1:0] pwdata,
	output logic [tpoh_pkg::DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	// Serial overhead port
	output logic poh_serial_clk,
	output logic poh_insert_window,
	output logic poh_frame_mark,
	input wire logic poh_serial_in,
	// Outbound SPE overhead
	input wire logic poh_take,
	input wire logic [7:0] trace_msg_byte,
	output logic [7:0] tx_j1_byte,
	output logic [7:0] tx_c2_byte,
	output logic [7:0] ctrl0_out,
	output logic [1:0] trace_length_select
);
	localparam logic [8:0] FRAME_LAST = 9'(FRAME_PERIODS - 1);
	localparam logic [8:0] WIN_END = 9'(tpoh_pkg::WIN_PERIODS);
	localparam logic [8:0] J1_LAST = 9'(tpoh_pkg::J1_LAST_PER);
	localparam logic [8:0] C2_LAST = 9'(tpoh_pkg::C2_LAST_PER);
	localparam logic [2:0] DIV_LAST = 3'(tpoh_pkg::SER_DIV - 1);
	localparam logic [2:0] HALF_LAST = 3'(tpoh_pkg::SER_HALF - 1);

	logic [7:0] ctrl0_reg;
	logic [3:0] trace_ctrl_reg;
	logic [7:0] label_value_reg;
	logic [7:0] j1_value_reg;
	logic [1:0] trace_source_select;
	logic signal_label_source;
	logic [2:0] div_cnt_reg;
	logic rise_evt;
	logic fall_evt;
	logic [8:0] per_cnt_reg;
	logic [8:0] per_cnt_next;
	logic in_meta_reg;
	logic in_sync_reg;
	logic [6:0] shift_reg;
	logic push_j1;
	logic push_c2;
	logic fifo_in_valid;
	logic fifo_in_ready;
	logic [tpoh_pkg::FIFO_W-1:0] fifo_in_data;
	logic fifo_out_valid;
	logic [tpoh_pkg::FIFO_W-1:0] fifo_out_data;
	logic pop;
	logic [7:0] j1_serial_reg;
	logic [7:0] c2_serial_reg;
	logic [7:0] overrun_reg;
	logic [11:0] reg_index;
	logic addr_ok;
	logic access;
	logic wr_commit;
	logic [tpoh_pkg::DATA_W-1:0] rd_mux;
	logic rd_hit;

	assign trace_source_select = trace_ctrl_reg[tpoh_pkg::TC_SRC_LO +: 2];
	assign signal_label_source = ctrl0_reg[tpoh_pkg::C0_LABEL_SRC];

	//------------------------------------------------------------
	// APB decode
	//------------------------------------------------------------
	// Two cycle access: pready is raised one cycle into the access phase
	assign reg_index = paddr[13:2];
	assign addr_ok = (paddr[1:0] == 2'h0) && (paddr[15:14] == 2'h0);
	assign access = psel && penable;
	assign wr_commit = access && pready && pwrite && !pslverr;

	// Read mux, unused bits read zero
	always_comb begin
		rd_mux = '0;
		rd_hit = addr_ok;
		unique case (reg_index)
			tpoh_pkg::IDX_CTRL0: rd_mux[7:0] = ctrl0_reg;
			tpoh_pkg::IDX_J1_VALUE: rd_mux[7:0] = j1_value_reg;
			tpoh_pkg::IDX_TRACE_CTRL: rd_mux[3:0] = trace_ctrl_reg;
			tpoh_pkg::IDX_LABEL_VALUE: rd_mux[7:0] = label_value_reg;
			tpoh_pkg::IDX_STATUS: rd_mux[24:0] = {fifo_out_valid,
				overrun_reg, c2_serial_reg, j1_serial_reg};
			default: rd_hit = 1'b0;
		endcase
	end

	// Answer registers; read data are held until the next answer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= '0;
		end else if (access && !pready) begin
			pready <= 1'b1;
			pslverr <= !rd_hit;
			prdata <= (!pwrite && rd_hit) ? rd_mux : '0;
		end else begin
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
	end

	// Software registers, written at the completing edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl0_reg <= tpoh_pkg::CTRL0_RST;
			trace_ctrl_reg <= tpoh_pkg::TRACE_CTRL_RST;
			label_value_reg <= tpoh_pkg::LABEL_RST;
			j1_value_reg <= tpoh_pkg::J1_VALUE_RST;
		end else if (wr_commit) begin
			unique case (reg_index)
				tpoh_pkg::IDX_CTRL0: ctrl0_reg <= pwdata[7:0] &
					tpoh_pkg::C0_WR_MASK;
				tpoh_pkg::IDX_TRACE_CTRL: trace_ctrl_reg <= pwdata[3:0];
				tpoh_pkg::IDX_LABEL_VALUE: label_value_reg <= pwdata[7:0];
				tpoh_pkg::IDX_J1_VALUE: j1_value_reg <= pwdata[7:0];
				default: ;
			endcase
		end
	end

	//------------------------------------------------------------
	// Serial clock, window and frame mark
	//------------------------------------------------------------
	assign rise_evt = (div_cnt_reg == DIV_LAST);
	assign fall_evt = (div_cnt_reg == HALF_LAST);
	assign per_cnt_next = (per_cnt_reg == FRAME_LAST) ? 9'h000 :
		per_cnt_reg + 9'h001;

	// Divider; the clock output itself is a flop for clean edges
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_cnt_reg <= 3'h0;
			poh_serial_clk <= 1'b0;
		end else begin
			div_cnt_reg <= rise_evt ? 3'h0 : div_cnt_reg + 3'h1;
			if (rise_evt) begin
				poh_serial_clk <= 1'b1;
			end else if (fall_evt) begin
				poh_serial_clk <= 1'b0;
			end
		end
	end

	// Window and mark change on falling edges so the partner sees
	// them settled at its rising sample point
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			per_cnt_reg <= FRAME_LAST;
			poh_insert_window <= 1'b0;
			poh_frame_mark <= 1'b0;
		end else if (fall_evt) begin
			per_cnt_reg <= per_cnt_next;
			poh_insert_window <= (per_cnt_next < WIN_END);
			poh_frame_mark <= (per_cnt_next == 9'h000);
		end
	end

	//------------------------------------------------------------
	// Serial capture
	//------------------------------------------------------------
	// Pin synchroniser; the bit is stable half a period before the rise
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			in_meta_reg <= 1'b0;
			in_sync_reg <= 1'b0;
		end else begin
			in_meta_reg <= poh_serial_in;
			in_sync_reg <= in_meta_reg;
		end
	end

	// MSB first shift at each rising edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			shift_reg <= 7'h00;
		end else if (rise_evt) begin
			shift_reg <= {shift_reg[5:0], in_sync_reg};
		end
	end

	// Whole bytes go to the FIFO only for the serial sources
	assign push_j1 = rise_evt && (per_cnt_reg == J1_LAST) &&
		(trace_source_select == tpoh_pkg::TSRC_SERIAL);
	assign push_c2 = rise_evt && (per_cnt_reg == C2_LAST) &&
		signal_label_source;
	assign fifo_in_valid = push_j1 || push_c2;
	assign fifo_in_data = {push_c2, shift_reg, in_sync_reg};

	// Count bytes lost because the drain side stalled
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			overrun_reg <= 8'h00;
		end else if (fifo_in_valid && !fifo_in_ready &&
			overrun_reg != 8'hFF) begin
			overrun_reg <= overrun_reg + 8'h01;
		end
	end

	tpoh_fifo #(
		.WIDTH(tpoh_pkg::FIFO_W),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.pclk(pclk),
		.presetn(presetn),
		.in_valid(fifo_in_valid),
		.in_ready(fifo_in_ready),
		.in_data(fifo_in_data),
		.out_valid(fifo_out_valid),
		.out_ready(poh_take),
		.out_data(fifo_out_data)
	);

	//------------------------------------------------------------
	// Outbound overhead bytes
	//------------------------------------------------------------
	assign pop = fifo_out_valid && poh_take;

	// Serial bytes are taken at the SPE overhead strobe
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			j1_serial_reg <= 8'h00;
			c2_serial_reg <= 8'h00;
		end else if (pop) begin
			if (fifo_out_data[8] == tpoh_pkg::TAG_J1) begin
				j1_serial_reg <= fifo_out_data[7:0];
			end else begin
				c2_serial_reg <= fifo_out_data[7:0];
			end
		end
	end

	// J1 source selection
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_j1_byte <= 8'h00;
		end else begin
			unique case (trace_source_select)
				tpoh_pkg::TSRC_ZERO: tx_j1_byte <= 8'h00;
				tpoh_pkg::TSRC_BUFFER: tx_j1_byte <= trace_msg_byte;
				tpoh_pkg::TSRC_REG: tx_j1_byte <= j1_value_reg;
				tpoh_pkg::TSRC_SERIAL: tx_j1_byte <= j1_serial_reg;
			endcase
		end
	end

	// C2 source selection
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_c2_byte <= 8'h00;
		end else if (signal_label_source) begin
			tx_c2_byte <= c2_serial_reg;
		end else begin
			tx_c2_byte <= label_value_reg;
		end
	end

	// Control fields out to the rest of the overhead logic
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl0_out <= tpoh_pkg::CTRL0_RST;
			trace_length_select <= 2'h0;
		end else begin
			ctrl0_out <= ctrl0_reg;
			trace_length_select <= trace_ctrl_reg[tpoh_pkg::TC_LEN_LO +: 2];
		end
	end

	//------------------------------------------------------------
	// Checks
	//------------------------------------------------------------
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	a_j1_serial_out:
	assert property ((trace_source_select == tpoh_pkg::TSRC_SERIAL)
		|=> tx_j1_byte == $past(j1_serial_reg))
	else $error("J1 not taken from serial byte");

	a_j1_zero_src:
	assert property ((trace_source_select == tpoh_pkg::TSRC_ZERO)
		|=> tx_j1_byte == 8'h00)
	else $error("J1 not zero");

	a_j1_reg_src:
	assert property ((trace_source_select == tpoh_pkg::TSRC_REG)
		|=> tx_j1_byte == $past(j1_value_reg))
	else $error("J1 not from value register");

	a_c2_label_reg:
	assert property (!signal_label_source ##1 !signal_label_source
		|-> tx_c2_byte == $past(label_value_reg))
	else $error("C2 not from label register");

	a_c2_serial_out:
	assert property (signal_label_source
		|=> tx_c2_byte == $past(c2_serial_reg))
	else $error("C2 not from serial byte");

	a_label_write:
	assert property (wr_commit && reg_index == tpoh_pkg::IDX_LABEL_VALUE
		|=> label_value_reg == $past(pwdata[7:0]))
	else $error("Label write lost");

	a_ctrl0_unused:
	assert property (ctrl0_reg[1] == 1'b0)
	else $error("Unused control bit set");

	a_trace_read_hi:
	assert property (access && !pready && !pwrite &&
		reg_index == tpoh_pkg::IDX_TRACE_CTRL
		|=> prdata[31:4] == '0 && pready)
	else $error("Trace control upper bits not zero");

	a_j1_capture_time:
	assert property (push_j1 |-> !poh_serial_clk &&
		!$past(poh_serial_clk) && per_cnt_reg == J1_LAST
		##1 poh_serial_clk)
	else $error("J1 byte captured off its rising edge");

	a_serial_period:
	assert property (rise_evt |=> !rise_evt [*7] ##1 rise_evt)
	else $error("Serial clock period wrong");

	a_pop_load:
	assert property (pop && fifo_out_data[8] == tpoh_pkg::TAG_J1
		|=> j1_serial_reg == $past(fifo_out_data[7:0]))
	else $error("Popped J1 byte not loaded");

	c_j1_push: cover property (push_j1 && fifo_in_ready);
	c_c2_push: cover property (push_c2 && fifo_in_ready);
	c_overrun: cover property (fifo_in_valid && !fifo_in_ready);
	c_pop_c2: cover property (pop && fifo_out_data[8]);
endmodule : tpoh_insert

// ==== verification/tpoh_overhead_source.sv ====
`timescale 1ns/1ns
//------------------------------------------------------------
// Serial overhead source beside the device
//------------------------------------------------------------
module tpoh_overhead_source (
	// Device timing outputs
	input wire logic poh_serial_clk,
	input wire logic poh_insert_window,
	input wire logic poh_frame_mark,
	// Bytes to send each frame
	input wire logic [7:0] j1_byte,
	input wire logic [7:0] c2_byte,
	// Serial data towards the device
	output logic poh_serial_in
);
	logic hit;
	int k;

	initial begin
		hit = 1'b0;
		k = 0;
		poh_serial_in = 1'b0;
	end

	// Sample window and frame on every rising edge
	always @(posedge poh_serial_clk) begin
		hit <= poh_insert_window & poh_frame_mark;
	end

	// Count fallings after the mark; idle line toggles so no stale bit
	always @(negedge poh_serial_clk) begin
		if (hit) begin
			k = 1;
		end else if (k != 0 && k < 24) begin
			k = k + 1;
		end else begin
			k = 0;
		end
		if (k >= 1 && k <= 8) begin
			poh_serial_in = j1_byte[8-k];
		end else if (k >= 17 && k <= 24) begin
			poh_serial_in = c2_byte[24-k];
		end else begin
			poh_serial_in = ~poh_serial_in;
		end
	end
	// No insert request pin is driven at all
endmodule : tpoh_overhead_source

// ==== verification/tb_tpoh_insert.sv ====
`timescale 1ns/1ns
//------------------------------------------------------------
// Bench for the overhead insert block
//------------------------------------------------------------
module tb_tpoh_insert;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [15:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic sclk, win, mark, sin, take, err;
	logic [7:0] msg, j1, c2, ctrl0, src_j1, src_c2;
	logic [1:0] tlen;
	int fail_count, checked;

	tpoh_insert #(.FRAME_PERIODS(100), .FIFO_DEPTH(4)) DUT (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .poh_serial_clk(sclk),
		.poh_insert_window(win), .poh_frame_mark(mark),
		.poh_serial_in(sin), .poh_take(take), .trace_msg_byte(msg),
		.tx_j1_byte(j1), .tx_c2_byte(c2), .ctrl0_out(ctrl0),
		.trace_length_select(tlen));

	tpoh_overhead_source partner (
		.poh_serial_clk(sclk), .poh_insert_window(win),
		.poh_frame_mark(mark), .j1_byte(src_j1), .c2_byte(src_c2),
		.poh_serial_in(sin));

	// 20 MHz clock
	always #25 pclk = ~pclk;

	//------------------------------------------------------------
	// Shared tasks
	//------------------------------------------------------------
	function automatic logic [15:0] ad(input logic [11:0] i);
		return {2'b00, i, 2'b00};
	endfunction : ad

	task summarize;
		$display("checks %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : summarize

	task chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected at %0t: got %h expected %h", $time, got,
				exp);
		end
	endtask : chk

	// One APB transfer, entered just after a rising edge
	task apb(input logic wr, input logic [15:0] a, input logic [31:0] wd);
		int n;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			fail_count++;
			summarize();
		end
		rd = prdata;
		err = pslverr;
		// Release, then let an edge pass so the next call never
		// reassigns psel in the same time step
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb

	// Wait until a signal reaches a level, bounded
	task wait_lvl(input int sel, input logic lvl);
		int n;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while ((sel == 0 ? mark : win) !== lvl && n < 2000);
		if ((sel == 0 ? mark : win) !== lvl) begin
			fail_count++;
			summarize();
		end
	endtask : wait_lvl

	task frame_start;
		wait_lvl(0, 1'b0);
		wait_lvl(0, 1'b1);
		chk({30'h0, win, mark}, 32'h3);
	endtask : frame_start

	task window_end;
		wait_lvl(1, 1'b1);
		wait_lvl(1, 1'b0);
	endtask : window_end

	//------------------------------------------------------------
	// Scenarios
	//------------------------------------------------------------
	task t_reset_values;
		apb(1'b0, ad(tpoh_pkg::IDX_CTRL0), 32'h0);
		chk(rd, 32'h0);
		apb(1'b0, ad(tpoh_pkg::IDX_TRACE_CTRL), 32'h0);
		chk(rd, 32'h0);
		apb(1'b0, ad(tpoh_pkg::IDX_LABEL_VALUE), 32'h0);
		chk(rd, 32'h0);
		apb(1'b1, 16'h0000, 32'hFF);
		chk({31'h0, err}, 32'h1);
		apb(1'b0, 16'h0000, 32'h0);
		chk({err, rd[30:0]}, 32'h80000000);
		$display("test reset_values done");
	endtask : t_reset_values

	task t_reg_access;
		apb(1'b1, ad(tpoh_pkg::IDX_CTRL0), 32'hFF);
		apb(1'b0, ad(tpoh_pkg::IDX_CTRL0), 32'h0);
		chk(rd, 32'hFD);
		chk({24'h0, ctrl0}, 32'hFD);
		apb(1'b1, ad(tpoh_pkg::IDX_TRACE_CTRL), 32'hFE);
		apb(1'b0, ad(tpoh_pkg::IDX_TRACE_CTRL), 32'h0);
		chk(rd, 32'h0E);
		chk({30'h0, tlen}, 32'h3);
		apb(1'b1, ad(tpoh_pkg::IDX_LABEL_VALUE), 32'h1A5);
		apb(1'b0, ad(tpoh_pkg::IDX_LABEL_VALUE), 32'h0);
		chk(rd, 32'hA5);
		apb(1'b1, ad(tpoh_pkg::IDX_CTRL0), 32'h0);
		$display("test reg_access done");
	endtask : t_reg_access

	// Software sources for J1 and C2
	task t_trace_modes;
		apb(1'b1, ad(tpoh_pkg::IDX_J1_VALUE), 32'h77);
		apb(1'b1, ad(tpoh_pkg::IDX_TRACE_CTRL), 32'h0);
		repeat (3) @(posedge pclk);
		chk({24'h0, j1}, 32'h0);
		apb(1'b1, ad(tpoh_pkg::IDX_TRACE_CTRL), 32'h1);
		repeat (3) @(posedge pclk);
		chk({24'h0, j1}, 32'hC3);
		apb(1'b1, ad(tpoh_pkg::IDX_TRACE_CTRL), 32'h2);
		repeat (3) @(posedge pclk);
		chk({24'h0, j1}, 32'h77);
		apb(1'b1, ad(tpoh_pkg::IDX_LABEL_VALUE), 32'h5E);
		repeat (3) @(posedge pclk);
		chk({24'h0, c2}, 32'h5E);
		$display("test trace_modes done");
	endtask : t_trace_modes

	// Serial bytes fill the FIFO while the outbound side stalls
	task t_serial_fill;
		take <= 1'b0;
		window_end();
		apb(1'b1, ad(tpoh_pkg::IDX_CTRL0), 32'h04);
		apb(1'b1, ad(tpoh_pkg::IDX_TRACE_CTRL), 32'h03);
		repeat (4) frame_start();
		apb(1'b0, ad(tpoh_pkg::IDX_STATUS), 32'h0);
		chk(rd, 32'h01020000);
		take <= 1'b1;
		repeat (10) @(posedge pclk);
		chk({16'h0, c2, j1}, 32'h3C96);
		apb(1'b0, ad(tpoh_pkg::IDX_STATUS), 32'h0);
		chk({7'h0, rd[24:0]}, 32'h00023C96);
		$display("test serial_fill done");
	endtask : t_serial_fill

	// A new source byte pair reaches the outbound slots in the next frame; checked two frames on
	task t_serial_stream;
		window_end();
		src_j1 <= 8'h5A;
		src_c2 <= 8'hE1;
		repeat (2) frame_start();
		repeat (4) @(posedge pclk);
		chk({16'h0, c2, j1}, 32'hE15A);
		$display("test serial_stream done");
	endtask : t_serial_stream

	//------------------------------------------------------------
	// Main sequence
	//------------------------------------------------------------
	initial begin
		pclk = 1'b0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 16'h0000;
		pwdata = 32'h0;
		take = 1'b1;
		msg = 8'hC3;
		src_j1 = 8'h96;
		src_c2 = 8'h3C;
		fail_count = 0;
		checked = 0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_reset_values();
		t_reg_access();
		t_trace_modes();
		t_serial_fill();
		t_serial_stream();
		summarize();
	end
endmodule : tb_tpoh_insert
